/* hdl/bus_bit_if.sv */
`timescale 1ns/1ps
// one bus bit per strobe, with a fault flag beside it
interface bus_bit_if;
    logic valid; // one-cycle strobe
    logic level; // bit value, 1 = recessive
    logic flag; // fault seen with this strobe
    modport src (output valid, output level, output flag);
    modport snk (input valid, input level, input flag);
endinterface : bus_bit_if

/* hdl/can_bit_sampler.sv */
`timescale 1ns/1ps
// ********************************
// bit timing: resync on falling edges, sample at the chosen point
// ********************************
module can_bit_sampler
    import can_trig_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic rx_level,
    input wire logic [11:0] period_cyc,
    input wire logic [11:0] sample_cyc,
    bus_bit_if.src smp
);
    logic rx_q; // line level one clock ago
    logic [11:0] cnt_q; // clocks since bit start
    logic [11:0] cnt_d;
    logic valid_q;
    logic level_q;
    wire edge_fall = rx_q & ~rx_level; // recessive to dominant
    // hard resync on every falling edge keeps long frames locked without
    // a phase-error window; costs tolerance to ringing on edges
    wire wrap = (cnt_q >= period_cyc - 12'h001);
    wire hit = ~edge_fall & (cnt_q == sample_cyc);
    assign cnt_d = edge_fall ? 12'h000 : (wrap ? 12'h000 : cnt_q + 12'h001);

    // counter and sample register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rx_q <= 1'b1;
            cnt_q <= 12'h000;
            valid_q <= 1'b0;
            level_q <= 1'b1;
        end
        else if (clk_en)
        begin
            rx_q <= rx_level;
            cnt_q <= cnt_d;
            valid_q <= hit;
            if (hit) level_q <= rx_level;
        end
    end

    assign smp.valid = valid_q;
    assign smp.level = level_q;
    assign smp.flag = 1'b0; // sampler reports no faults
endmodule : can_bit_sampler

/* hdl/can_destuffer.sv */
`timescale 1ns/1ps
// ********************************
// stuff bit removal and stuff error detection
// ********************************
module can_destuffer
    import can_trig_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic enable,
    bus_bit_if.snk raw,
    bus_bit_if.src bits
);
    logic [2:0] run_q; // length of the current run of equal bits
    logic last_q; // level of that run
    logic valid_q;
    logic level_q;
    logic err_q;
    wire same = (raw.level == last_q);
    wire stuff_slot = enable & (run_q == STUFF_RUN);
    wire [2:0] run_next = same ? ((run_q == IDLE_RUN) ? run_q : run_q + 3'h1) : 3'h1;

    // runs are tracked even while idle, so the start bit opens a run of one
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            run_q <= 3'h0;
            last_q <= 1'b1;
            valid_q <= 1'b0;
            level_q <= 1'b1;
            err_q <= 1'b0;
        end
        else if (clk_en)
        begin
            valid_q <= raw.valid & ~stuff_slot;
            err_q <= raw.valid & ((stuff_slot & same) | raw.flag);
            if (raw.valid)
            begin
                last_q <= raw.level;
                level_q <= raw.level;
                // a stuff bit always opens a fresh run
                run_q <= stuff_slot ? 3'h1 : run_next;
            end
        end
    end

    assign bits.valid = valid_q;
    assign bits.level = level_q;
    assign bits.flag = err_q;
endmodule : can_destuffer

/* hdl/can_frame_trigger_matcher.sv */
// What this block does
// - holds 64-bit data value and mask
// - value bit gives expected data level
// - mask zero ignores that data bit
// - data length is 1 to 8 bytes
// - compares data frames' data field to pattern in data mode
// - load keeps only the low length bytes
// - length change adds/drops bytes at low end
// - holds 32-bit identifier value and mask
// - value bit gives expected identifier level
// - mask zero excludes that identifier bit
// - compares every identifier under chosen mode
// - keeps 11 or 29 identifier bits
// - mode change adds/drops top identifier bits
// - standard 11-bit or extended 29-bit identifiers
// - samples bits at selectable fraction of bit
// - twelve standard bit rates, 10k to 1M
// - unsupported rate rounds up to next one
// - pattern settings need the decode option
// - data mode needs id, data, length match
// - identifier mode fires on data or remote
`timescale 1ns/1ps
module can_frame_trigger_matcher
    import can_trig_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic can_rx,
    input wire logic licensed_decode_option,
    input wire logic data_pattern_load,
    input wire logic [63:0] data_value_in,
    input wire logic [63:0] data_mask_in,
    input wire logic data_length_load,
    input wire logic [3:0] data_length_in,
    input wire logic identifier_pattern_setting,
    input wire logic [31:0] id_value_in,
    input wire logic [31:0] id_mask_in,
    input wire logic id_mode_load,
    input wire logic identifier_width_select,
    input wire logic [2:0] bit_sample_fraction,
    input wire logic baud_load,
    input wire logic [19:0] baud_request,
    input wire logic identifier_any_frame_match,
    output logic trigger,
    output logic hw_missing_error,
    output logic length_error,
    output logic [3:0] baud_code,
    output logic [3:0] data_length,
    output logic id_extended,
    output logic frame_active
);

    // ********************************
    // configuration storage
    // ********************************
    logic [63:0] data_val_q, data_val_d; // expected data levels
    logic [63:0] data_msk_q, data_msk_d; // data bits that take part
    logic [3:0] len_q, len_d; // data pattern length in bytes
    logic [31:0] id_val_q, id_val_d; // expected identifier levels
    logic [31:0] id_msk_q, id_msk_d; // identifier bits that take part
    logic ext_q; // 1 = extended identifiers
    logic [3:0] baud_q; // index into the rate table
    logic [11:0] period_q; // clocks per bit
    logic [11:0] sample_q; // clocks to the sample point
    logic hwerr_q; // pulse: setting refused, option missing
    logic lenerr_q; // pulse: length outside 1..8

    // move the stored pattern so bytes come and go at the low end
    function automatic logic [63:0] shift_bytes(input logic [63:0] v,
                                                input logic [3:0] old_len,
                                                input logic [3:0] new_len);
        logic [6:0] amt;
        amt = 7'h00;
        if (new_len >= old_len)
        begin
            amt = {new_len - old_len, 3'b000};
            return (v << amt) & byte_mask(new_len);
        end
        amt = {old_len - new_len, 3'b000};
        return v >> amt;
    endfunction : shift_bytes

    // gated writes: pattern settings only land with the option present
    wire wr_data = data_pattern_load & licensed_decode_option;
    wire wr_len_any = data_length_load & licensed_decode_option;
    wire wr_id = identifier_pattern_setting & licensed_decode_option;
    wire wr_mode = id_mode_load & licensed_decode_option;
    wire refused = ~licensed_decode_option &
        (data_pattern_load | data_length_load | identifier_pattern_setting | id_mode_load);
    wire len_ok = (data_length_in != 4'h0) && (data_length_in <= DATA_MAX_BYTES);
    wire wr_len = wr_len_any & len_ok;
    wire [3:0] len_next = wr_len ? data_length_in : len_q;
    wire ext_next = wr_mode ? identifier_width_select : ext_q;
    wire [63:0] len_mask = byte_mask(len_next);
    wire [31:0] width_mask = id_width_mask(ext_next);

    // a pattern load beats a length shift in the same cycle
    assign len_d = len_next;
    assign data_val_d = wr_data ? data_value_in & len_mask :
                        wr_len ? shift_bytes(data_val_q, len_q, len_next) :
                        data_val_q;
    assign data_msk_d = wr_data ? data_mask_in & len_mask :
                        wr_len ? shift_bytes(data_msk_q, len_q, len_next) :
                        data_msk_q;
    // widening leaves zero top bits, narrowing drops them
    assign id_val_d = wr_id ? id_value_in & width_mask :
                      wr_mode ? id_val_q & width_mask : id_val_q;
    assign id_msk_d = wr_id ? id_mask_in & width_mask :
                      wr_mode ? id_msk_q & width_mask : id_msk_q;

    // configuration registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            data_val_q <= DATA_RST;
            data_msk_q <= DATA_RST;
            len_q <= DATA_LEN_RST;
            id_val_q <= ID_RST;
            id_msk_q <= ID_RST;
            ext_q <= ID_EXT_RST;
            baud_q <= BAUD_CODE_RST;
            period_q <= BIT_CYC[BAUD_CODE_RST];
            sample_q <= 12'h000;
            hwerr_q <= 1'b0;
            lenerr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            data_val_q <= data_val_d;
            data_msk_q <= data_msk_d;
            len_q <= len_d;
            id_val_q <= id_val_d;
            id_msk_q <= id_msk_d;
            ext_q <= ext_next;
            if (baud_load) baud_q <= baud_select(baud_request);
            // timing follows the rate a clock later; harmless between frames
            period_q <= BIT_CYC[baud_q];
            sample_q <= sample_cycles(BIT_CYC[baud_q], bit_sample_fraction);
            hwerr_q <= refused;
            lenerr_q <= wr_len_any & ~len_ok;
        end
    end

    // ********************************
    // bit recovery
    // ********************************
    bus_bit_if raw_bits ();
    bus_bit_if dbits ();
    frame_state_e state_q, state_d;
    wire in_frame = (state_q != ST_IDLE) && (state_q != ST_REST);

    // sampling is only as good as the rate setting matches the bus
    can_bit_sampler u_sampler (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .rx_level(can_rx),
        .period_cyc(period_q),
        .sample_cyc(sample_q),
        .smp(raw_bits)
    );

    can_destuffer u_destuffer (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .enable(in_frame),
        .raw(raw_bits),
        .bits(dbits)
    );

    // ********************************
    // frame walker and comparators
    // ********************************
    logic [5:0] bitcnt_q; // bit index inside the current field
    logic [28:0] id_sh_q; // identifier bits, first received on top
    logic [63:0] data_sh_q; // data bits, first byte on top
    logic [3:0] dlc_q; // received length code
    logic rtr_q; // remote request bit
    logic ide_q; // frame carries an extended identifier
    logic [2:0] rest_q; // recessive run while waiting for idle
    logic trigger_q;
    logic active_q; // in_frame, registered so the pin comes from a flop

    wire bv = dbits.valid;
    wire b = dbits.level;
    wire [63:0] data_next = {data_sh_q[62:0], b};
    wire [3:0] dlc_next = {dlc_q[2:0], b};
    wire [3:0] dlc_eff = (dlc_q > DATA_MAX_BYTES) ? DATA_MAX_BYTES : dlc_q;
    wire last_data_bit = (bitcnt_q == {dlc_eff[2:0] - 3'h1, 3'b111});
    // value bit gives the level, mask bit of zero drops it out
    wire id_hit = (((32'(id_sh_q) ^ id_val_q) & id_msk_q) == 32'h0);
    wire data_hit = (((data_next ^ data_val_q) & data_msk_q) == 64'h0);
    wire fire_id = bv & identifier_any_frame_match & id_hit &
        (((state_q == ST_IDE) & ~b & ~ext_q) | ((state_q == ST_RTR_B) & ext_q));
    wire fire_data = bv & ~identifier_any_frame_match & (state_q == ST_DATA) &
        last_data_bit & ~rtr_q & (dlc_q == len_q) & (ide_q == ext_q) & id_hit & data_hit;

    // next state on each recovered bit; a stuff error abandons the frame
    always_comb
    begin
        state_d = state_q;
        if (dbits.flag)
            state_d = ST_REST;
        else if (bv)
        begin
            case (state_q)
                ST_IDLE: if (!b) state_d = ST_ID_A;
                ST_ID_A: if (bitcnt_q == 6'(STD_ID_BITS - 1)) state_d = ST_SRR;
                ST_SRR: state_d = ST_IDE;
                ST_IDE: state_d = b ? ST_ID_B : ST_R0;
                ST_ID_B: if (bitcnt_q == 6'(EXT_ID_BITS - STD_ID_BITS - 1)) state_d = ST_RTR_B;
                ST_RTR_B: state_d = ST_R1;
                ST_R1: state_d = ST_R0;
                ST_R0: state_d = ST_DLC;
                ST_DLC:
                    if (bitcnt_q == 6'h03)
                        state_d = (rtr_q || dlc_next == 4'h0) ? ST_REST : ST_DATA;
                ST_DATA: if (last_data_bit) state_d = ST_REST;
                ST_REST: if (b && rest_q == IDLE_RUN - 3'h1) state_d = ST_IDLE;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // field counters and shift registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            bitcnt_q <= 6'h00;
            id_sh_q <= 29'h0;
            data_sh_q <= 64'h0;
            dlc_q <= 4'h0;
            rtr_q <= 1'b0;
            ide_q <= 1'b0;
            rest_q <= 3'h0;
            trigger_q <= 1'b0;
            active_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            trigger_q <= fire_id | fire_data;
            active_q <= (state_d != ST_IDLE) && (state_d != ST_REST);
            if (bv)
            begin
                bitcnt_q <= (state_d != state_q) ? 6'h00 : bitcnt_q + 6'h01;
                rest_q <= b ? rest_q + 3'h1 : 3'h0;
                if (state_q == ST_IDLE)
                begin
                    id_sh_q <= 29'h0; // stale bits must not leak into a new compare
                    data_sh_q <= 64'h0;
                end
                if (state_q == ST_ID_A || state_q == ST_ID_B) id_sh_q <= {id_sh_q[27:0], b};
                if (state_q == ST_SRR || state_q == ST_RTR_B) rtr_q <= b;
                if (state_q == ST_IDE) ide_q <= b;
                if (state_q == ST_DLC) dlc_q <= dlc_next;
                if (state_q == ST_DATA) data_sh_q <= data_next;
            end
        end
    end

    assign trigger = trigger_q;
    assign hw_missing_error = hwerr_q;
    assign length_error = lenerr_q;
    assign baud_code = baud_q;
    assign data_length = len_q;
    assign id_extended = ext_q;
    assign frame_active = active_q;

    // ********************************
    // assertions
    // ********************************
    property p_refused_setting;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && data_length_load && !licensed_decode_option)
            |=> (hwerr_q && $stable(len_q));
    endproperty
    a_refused_setting: assert property (p_refused_setting)
        else $error("unlicensed length write was not refused");

    property p_len_range;
        @(posedge clock) disable iff (!rst_n)
        (len_q >= 4'h1) && (len_q <= DATA_MAX_BYTES);
    endproperty
    a_len_range: assert property (p_len_range)
        else $error("data length left 1..8");

    property p_data_trunc;
        @(posedge clock) disable iff (!rst_n)
        ((data_val_q | data_msk_q) & ~byte_mask(len_q)) == 64'h0;
    endproperty
    a_data_trunc: assert property (p_data_trunc)
        else $error("data pattern holds bytes beyond the length");

    property p_len_grow;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && wr_len && !wr_data && data_length_in == len_q + 4'h1)
            |=> (data_val_q == {$past(data_val_q[55:0]), 8'h00});
    endproperty
    a_len_grow: assert property (p_len_grow)
        else $error("length growth did not add a low byte");

    property p_id_width;
        @(posedge clock) disable iff (!rst_n)
        ((id_val_q | id_msk_q) & ~id_width_mask(ext_q)) == 32'h0;
    endproperty
    a_id_width: assert property (p_id_width)
        else $error("identifier pattern wider than mode");

    property p_mode_narrow;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && wr_mode && !wr_id && !identifier_width_select)
            |=> (id_val_q[10:0] == $past(id_val_q[10:0]) && !ext_q);
    endproperty
    a_mode_narrow: assert property (p_mode_narrow)
        else $error("narrowing lost the low identifier bits");

    property p_baud_round;
        @(posedge clock) disable iff (!rst_n)
        // fast enough for the request, and nothing slower would have done
        (clk_en && baud_load) |=> ((RATE_TABLE[baud_q] >= 32'($past(baud_request)))
            || (baud_q == RATE_CODE_MAX)) && ((baud_q == 4'h0)
            || (RATE_TABLE[baud_q - 4'h1] < 32'($past(baud_request))));
    endproperty
    a_baud_round: assert property (p_baud_round)
        else $error("rate was not rounded up");

    sequence s_match_seen;
        clk_en && (fire_id || fire_data);
    endsequence
    property p_trigger_pulse;
        @(posedge clock) disable iff (!rst_n)
        s_match_seen |=> trigger_q ##1 (!trigger_q || !$past(clk_en));
    endproperty
    a_trigger_pulse: assert property (p_trigger_pulse)
        else $error("trigger did not pulse once on a match");

    property p_data_fire_len;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && fire_data) |-> (dlc_q == len_q && !rtr_q && state_d == ST_REST);
    endproperty
    a_data_fire_len: assert property (p_data_fire_len)
        else $error("data trigger without length match");

endmodule : can_frame_trigger_matcher

/* hdl/can_trig_pkg.sv */
package can_trig_pkg;

    // ********************************
    // clock and bit timing
    // ********************************
    localparam int unsigned CLOCK_HZ = 25_000_000; // system clock rate
    localparam int unsigned RATE_COUNT = 12; // number of standard bit rates
    // supported bit rates, slowest first, in bits per second
    localparam int unsigned RATE_TABLE [RATE_COUNT] = '{
        10000, 20000, 33300, 50000, 62500, 83300,
        100000, 125000, 250000, 500000, 800000, 1000000};
    // clocks per bus bit for each rate; fractions are dropped
    localparam logic [11:0] BIT_CYC [RATE_COUNT] = '{
        12'(CLOCK_HZ / RATE_TABLE[0]), 12'(CLOCK_HZ / RATE_TABLE[1]),
        12'(CLOCK_HZ / RATE_TABLE[2]), 12'(CLOCK_HZ / RATE_TABLE[3]),
        12'(CLOCK_HZ / RATE_TABLE[4]), 12'(CLOCK_HZ / RATE_TABLE[5]),
        12'(CLOCK_HZ / RATE_TABLE[6]), 12'(CLOCK_HZ / RATE_TABLE[7]),
        12'(CLOCK_HZ / RATE_TABLE[8]), 12'(CLOCK_HZ / RATE_TABLE[9]),
        12'(CLOCK_HZ / RATE_TABLE[10]), 12'(CLOCK_HZ / RATE_TABLE[11])};
    localparam logic [3:0] RATE_CODE_MAX = 4'hB; // index of the fastest rate
    localparam int unsigned PERMILLE_FULL = 1000; // whole bit time in per mille
    // sample point per code: 60, 62.5, 68, 70, 75, 80, 87.5 percent; code 7 repeats 87.5
    localparam logic [9:0] SAMPLE_PERMILLE [8] = '{
        10'h258, 10'h271, 10'h2A8, 10'h2BC, 10'h2EE, 10'h320, 10'h36B, 10'h36B};

    // ********************************
    // frame layout and reset values
    // ********************************
    localparam int unsigned STD_ID_BITS = 11; // standard identifier width
    localparam int unsigned EXT_ID_BITS = 29; // extended identifier width
    localparam logic [3:0] DATA_MAX_BYTES = 4'h8; // longest data pattern
    localparam logic [3:0] DATA_LEN_RST = 4'h1; // data length after reset
    localparam logic [3:0] BAUD_CODE_RST = RATE_CODE_MAX; // 1 Mb/s after reset
    localparam logic ID_EXT_RST = 1'b0; // standard identifiers after reset
    localparam logic [63:0] DATA_RST = 64'h0; // data value and mask reset
    localparam logic [31:0] ID_RST = 32'h0; // identifier value and mask reset
    localparam logic [2:0] STUFF_RUN = 3'h5; // equal bits before a stuff bit
    localparam logic [2:0] IDLE_RUN = 3'h7; // recessive bits that end a frame

    // frame walker states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ID_A, ST_SRR, ST_IDE, ST_ID_B, ST_RTR_B,
        ST_R1, ST_R0, ST_DLC, ST_DATA, ST_REST
    } frame_state_e;

    // mask covering the low len bytes
    function automatic logic [63:0] byte_mask(input logic [3:0] len);
        logic [63:0] m;
        m = 64'h0;
        for (int i = 0; i < 8; i++)
            if (i < int'(len)) m[i*8 +: 8] = 8'hFF;
        return m;
    endfunction : byte_mask

    // mask covering the identifier bits of the chosen width
    function automatic logic [31:0] id_width_mask(input logic ext);
        return ext ? 32'h1FFF_FFFF : 32'h0000_07FF;
    endfunction : id_width_mask

    // smallest supported rate not below the request, else the fastest
    function automatic logic [3:0] baud_select(input logic [19:0] req);
        logic [3:0] code;
        code = RATE_CODE_MAX;
        for (int i = RATE_COUNT - 1; i >= 0; i--)
            if (RATE_TABLE[i] >= 32'(req)) code = 4'(i);
        return code;
    endfunction : baud_select

    // clocks from bit start to the sample point
    function automatic logic [11:0] sample_cycles(input logic [11:0] period,
                                                  input logic [2:0] frac);
        return 12'((32'(period) * 32'(SAMPLE_PERMILLE[frac])) / PERMILLE_FULL);
    endfunction : sample_cycles

endpackage : can_trig_pkg

/* test/can_node_model.sv */
`timescale 1ns/1ps
// ********************************
// bus node: stuffed frames, 25 clocks a bit
// ********************************
module can_node_model
(
    input wire logic clock,
    output logic can_rx
);
    int run; // equal bits in a row
    logic last; // previous bit on the wire
    initial can_rx = 1'b1; // recessive while idle
    // one bit time at 1 Mb/s, the rate the matcher runs at
    task automatic hold(input logic b);
        @(posedge clock);
        can_rx <= b;
        repeat (24) @(posedge clock);
    endtask : hold
    // stuff bit after five equal bits, else the matcher drops the frame
    task automatic tx(input logic b);
        hold(b);
        run = (b == last) ? run + 1 : 1;
        last = b;
        if (run == 5)
        begin
            hold(!b);
            run = 1;
            last = !b;
        end
    endtask : tx
    // header and data only; the tail is plain recessive; id bit 29 set = extended
    task automatic send(input logic [29:0] id, input logic rtr, input logic [3:0] dlc,
                        input logic [63:0] data);
        run = 0;
        last = 1'b1;
        tx(1'b0);
        if (id[29])
        begin
            for (int i = 28; i >= 18; i--) tx(id[i]);
            tx(1'b1); // substitute remote bit
            tx(1'b1); // extended format flag
            for (int i = 17; i >= 0; i--) tx(id[i]);
        end
        else
            for (int i = 10; i >= 0; i--) tx(id[i]);
        tx(rtr);
        tx(1'b0);
        tx(1'b0);
        for (int i = 3; i >= 0; i--) tx(dlc[i]);
        for (int i = 8 * dlc - 1; i >= 0; i--) tx(data[i]);
        repeat (11) hold(1'b1);
    endtask : send
endmodule : can_node_model

/* test/tb_top.sv */
`timescale 1ns/1ps
// ********************************
// matcher bench
// ********************************
module tb_top
    import can_trig_pkg::*;
;
    typedef struct packed {logic [19:0] req; logic [3:0] code;} row_s; // baud row
    row_s rows [6] = '{'{20'h02710, 4'h0}, '{20'h08215, 4'h3}, '{20'hC3500, 4'hA},
                       '{20'hDBBA0, 4'hB}, '{20'h00001, 4'h0}, '{20'hF4240, 4'hB}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic opt = 1'b0, md = 1'b0, any = 1'b0; // option, mode, any-frame
    logic [2:0] sf = 3'h4; // sample point code, 75 percent
    logic [4:0] ld = 5'h0; // load strobes
    logic [63:0] dv = 64'h0, dm = 64'h0;
    logic [31:0] iv = 32'h0, im = 32'h0;
    logic [3:0] dl = 4'h0;
    logic [19:0] br = 20'h0;
    wire can_rx, trigger, hw_err, len_err, id_ext, fa;
    wire [3:0] bcode, dlen;
    int n_fail = 0, check_count = 0, hits = 0, hw = 0, le = 0, act = 0;
    always #20 clock = ~clock;
    // pulse counters, so the exact pulse cycle does not matter
    always @(posedge clock)
    begin
        hits <= hits + int'(trigger === 1'b1);
        hw <= hw + int'(hw_err === 1'b1);
        le <= le + int'(len_err === 1'b1);
        act <= act + int'(fa === 1'b1);
    end
    can_frame_trigger_matcher can_frame_trigger_matcher_i (.clock(clock), .rst_n(rst_n),
        .clk_en(1'b1), .can_rx(can_rx), .licensed_decode_option(opt),
        .data_pattern_load(ld[0]), .data_value_in(dv), .data_mask_in(dm),
        .data_length_load(ld[1]), .data_length_in(dl), .identifier_pattern_setting(ld[2]),
        .id_value_in(iv), .id_mask_in(im), .id_mode_load(ld[3]),
        .identifier_width_select(md), .bit_sample_fraction(sf), .baud_load(ld[4]),
        .baud_request(br), .identifier_any_frame_match(any), .trigger(trigger),
        .hw_missing_error(hw_err), .length_error(len_err), .baud_code(bcode),
        .data_length(dlen), .id_extended(id_ext), .frame_active(fa));
    can_node_model can_node_model_i (.clock(clock), .can_rx(can_rx));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // one-cycle strobe, then room for the settings to land
    task automatic strobe(input int k);
        @(posedge clock);
        ld[k] <= 1'b1;
        @(posedge clock);
        ld <= 5'h0;
        repeat (3) @(posedge clock);
    endtask : strobe
    // counts against a snapshot, so the pulse counter keeps a single writer
    task automatic frame(input logic [29:0] id, input logic rtr, input logic [3:0] dlc,
                         input logic [63:0] data, input int exp);
        int base; // pulses seen before this frame
        base = hits;
        can_node_model_i.send(id, rtr, dlc, data);
        chk(hits - base, exp);
    endtask : frame
    task automatic test_done;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // watchdog, far past the ten or so frames
    initial
    begin
        #2_000_000;
        n_fail++;
        test_done;
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk({bcode, dlen, id_ext, trigger, hw_err, len_err}, {BAUD_CODE_RST, 8'h10});
        @(posedge clock);
        foreach (rows[i])
        begin
            br <= rows[i].req;
            strobe(4);
            chk(bcode, rows[i].code);
        end
        dl <= 4'h3;
        strobe(1);
        chk({hw, dlen}, {32'h1, 4'h1});
        opt <= 1'b1;
        dl <= 4'h9;
        strobe(1);
        chk({le, dlen}, {32'h1, 4'h1});
        for (int m = 1; m >= 0; m--)
        begin
            md <= 1'(m);
            strobe(3);
            chk(id_ext, 64'(m));
        end
        // high bits beyond 11 and beyond two bytes must be dropped
        iv <= 32'hFFFF_F123;
        im <= 32'hFFFF_FFFF;
        strobe(2);
        dv <= 64'h1234_5678_FFFF_ABCD;
        dm <= 64'hFFFF_FFFF_FFFF_FFFF;
        dl <= 4'h2;
        strobe(1);
        strobe(0);
        frame(11'h123, 1'b0, 4'h2, 64'hABCD, 1);
        chk({act != 0, fa}, 2'h2);
        frame(11'h123, 1'b0, 4'h2, 64'hABCE, 0);
        frame(11'h124, 1'b0, 4'h2, 64'hABCD, 0);
        dm <= 64'hFF00;
        strobe(0);
        frame(11'h123, 1'b0, 4'h2, 64'hAB55, 1);
        dl <= 4'h3;
        strobe(1);
        frame(11'h123, 1'b0, 4'h3, 64'hAB5555, 1);
        frame(11'h123, 1'b0, 4'h2, 64'hABCD, 0);
        im <= 32'h0000_07F0;
        strobe(2);
        any <= 1'b1;
        frame(11'h12F, 1'b1, 4'h0, 64'h0, 1);
        // widened mode: a standard frame no longer qualifies
        md <= 1'b1;
        sf <= 3'h6;
        strobe(3);
        frame(11'h12F, 1'b0, 4'h1, 64'h0, 0);
        // narrowed again: the low identifier bits survive both changes
        md <= 1'b0;
        strobe(3);
        frame(11'h12F, 1'b0, 4'h1, 64'h0, 1);
        md <= 1'b1;
        strobe(3);
        iv <= 32'hF2AB_CDEF;
        im <= 32'hFFFF_FFFF;
        strobe(2);
        frame(30'h32AB_CDEF, 1'b1, 4'h0, 64'h0, 1);
        any <= 1'b0;
        frame(30'h32AB_CDEF, 1'b0, 4'h3, 64'hAB5555, 1);
        frame(30'h32AB_CDEE, 1'b0, 4'h3, 64'hAB5555, 0);
        // mid-run reset brings the settings back to their defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk({dlen, id_ext, fa}, {DATA_LEN_RST, ID_EXT_RST, 1'b0});
        test_done;
    end
endmodule : tb_top
